//--- sbrg_monitor.sv
// Checker for the baud generator register bus and tick outputs
`timescale 1ns/1ns
module sbrg_monitor
	import sbrg_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       writedata,
	input wire logic [3:0]        byteenable,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	input wire sbrg_tx_ctrl_t     tx_ctrl,
	input wire logic              sample_tick,
	input wire logic              bit_tick,
	input wire logic              rx_level
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Accepted write to one register
	wire wr_tx  = write && !waitrequest && address == 10'h260 && byteenable[0];
	wire wr_div = write && !waitrequest && address == 10'h264 && byteenable[0];

	wait_first_a: assert property ($rose(read || write) |-> waitrequest)
		else $error("request not held off in its first cycle");
	wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("more than one wait cycle");
	idle_nowait_a: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest while idle");
	upper_zero_a: assert property (read && !waitrequest |->
		readdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	rst_values_a: assert property (disable iff (1'b0)
		rst |=> tx_ctrl == '0 && !sample_tick && !bit_tick && rx_level)
		else $error("outputs not cleared by reset");
	mode_store_a: assert property (wr_tx |=>
		tx_ctrl.sync_mode == $past(writedata[4]) &&
		tx_ctrl.high_speed_select == $past(writedata[2]))
		else $error("mode bits not stored");
	restart_tick_a: assert property (wr_div && !tx_ctrl.sync_mode |->
		##[1:3] sample_tick)
		else $error("timer not restarted by divisor write");
	// External clock leaves the generator idle
	slave_quiet_a: assert property ((tx_ctrl.sync_mode &&
		!tx_ctrl.clock_source_select) [*3] |-> !sample_tick && !bit_tick)
		else $error("ticks while clock is external");

	cover property (bit_tick && tx_ctrl.high_speed_select && !tx_ctrl.sync_mode);
	cover property (bit_tick && tx_ctrl.sync_mode);
	cover property ($fell(rx_level));
endmodule

//--- sbrg_pkg.sv
// Package for the serial port baud rate generator: map, fields, counts
package sbrg_pkg;

	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned ADDR_W          = 10;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_RX_CTRL      = 8'h18;
	localparam logic [7:0] IDX_TX_CTRL      = 8'h98;
	localparam logic [7:0] IDX_BAUD_DIV     = 8'h99;

	// Transmit control and status field positions
	localparam int unsigned TX_CLOCK_SOURCE_SELECT_BIT     = 7;
	localparam int unsigned TX_TX9_BIT      = 6;
	localparam int unsigned TX_TXEN_BIT     = 5;
	localparam int unsigned TX_SYNC_BIT     = 4;
	localparam int unsigned TX_HIGH_SPEED_SELECT_BIT     = 2;
	localparam int unsigned TX_TRMT_BIT     = 1;
	localparam int unsigned TX_TX9D_BIT     = 0;

	// Receive control and status field positions
	localparam int unsigned RX_PORT_ENABLE_BIT     = 7;
	localparam int unsigned RX_RX9_BIT      = 6;
	localparam int unsigned RX_SREN_BIT     = 5;
	localparam int unsigned RX_CREN_BIT     = 4;
	localparam int unsigned RX_ADDEN_BIT    = 3;
	localparam int unsigned RX_FERR_BIT     = 2;
	localparam int unsigned RX_OERR_BIT     = 1;
	localparam int unsigned RX_RX9D_BIT     = 0;

	// Values after reset
	localparam logic [7:0] TX_CTRL_RESET    = 8'h02;
	localparam logic [7:0] RX_CTRL_RESET    = 8'h00;
	localparam logic [7:0] BAUD_DIV_RESET   = 8'h00;

	// Oscillator cycles per timer tick in synchronous mode, minus one
	localparam logic [1:0] PRESC_SYNC_LAST  = 2'h3;
	// Timer pulses per bit in asynchronous mode, minus one
	localparam logic [5:0] POST_HIGH_LAST   = 6'h0F;
	localparam logic [5:0] POST_LOW_LAST    = 6'h3F;

	typedef struct packed {
		logic clock_source_select;
		logic tx9;
		logic txen;
		logic sync_mode;
		logic high_speed_select;
		logic tx9d;
	} sbrg_tx_ctrl_t;

	typedef struct packed {
		logic port_enable;
		logic rx9;
		logic sren;
		logic cren;
		logic adden;
	} sbrg_rx_ctrl_t;

	typedef struct packed {
		logic framing_error;
		logic overrun_error;
		logic rx_ninth_bit;
	} sbrg_rx_stat_t;

endpackage

//--- sbrg_top.sv
// Baud rate generator with register slave and receive pin majority detect
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - Bit clock from free-running 8-bit timer
// - Divisor spans 0 to 255, all valid
// - Async low speed: fosc/(64(X+1))
// - Async high speed: fosc/(16(X+1))
// - Sync: fosc/(4(X+1)), no high speed
// - High-speed bit 2 acts in async only
// - Sync mode ignores high-speed select
// - Sync rates apply only as internal clock master
// - Divisor write clears timer immediately
// - Receive pin level by three-sample majority in async
// - Output samples at x16 or x64 bit rate in async, x1 in sync
// - Mode bit 4 clear async, set sync
module sbrg_top
	import sbrg_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  wire logic              tsr_empty,
	input  wire sbrg_rx_stat_t     rx_status,
	input  wire logic              receive_data_pin,
	output sbrg_tx_ctrl_t          tx_ctrl,
	output sbrg_rx_ctrl_t          rx_ctrl,
	output logic                   sample_tick,
	output logic                   bit_tick,
	output logic                   rx_level
);

	logic              ack_q;
	logic [31:0]       readdata_q;
	logic [7:0]        rd_byte;
	logic              req;
	logic              hit_word;
	logic [7:0]        idx;
	logic              wr_en;
	sbrg_tx_ctrl_t     tx_ctrl_q;
	sbrg_rx_ctrl_t     rx_ctrl_q;
	logic [7:0]        baud_divisor_value_q;
	logic              div_write;
	logic              gen_run;
	logic [1:0]        presc_q;
	logic              presc_tick;
	logic [7:0]        bit_rate_timer_q;
	logic              timer_pulse;
	logic [5:0]        post_q;
	logic [5:0]        post_last;
	logic              sample_tick_q;
	logic              bit_tick_q;
	logic [2:0]        pin_sync_q;
	logic              pin_level_q;
	logic [2:0]        votes_q;
	logic              rx_level_q;

	// Bus slave: one wait cycle, then the access completes
	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign hit_word    = (address[1:0] == 2'h0);
	assign idx         = address[ADDR_W-1:2];
	assign wr_en       = write & ack_q & hit_word & byteenable[0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (hit_word) begin
			if (idx == IDX_TX_CTRL) begin
				rd_byte[TX_CLOCK_SOURCE_SELECT_BIT] = tx_ctrl_q.clock_source_select;
				rd_byte[TX_TX9_BIT]  = tx_ctrl_q.tx9;
				rd_byte[TX_TXEN_BIT] = tx_ctrl_q.txen;
				rd_byte[TX_SYNC_BIT] = tx_ctrl_q.sync_mode;
				rd_byte[TX_HIGH_SPEED_SELECT_BIT] = tx_ctrl_q.high_speed_select;
				rd_byte[TX_TRMT_BIT] = tsr_empty;
				rd_byte[TX_TX9D_BIT] = tx_ctrl_q.tx9d;
			end else if (idx == IDX_RX_CTRL) begin
				rd_byte[RX_PORT_ENABLE_BIT]  = rx_ctrl_q.port_enable;
				rd_byte[RX_RX9_BIT]   = rx_ctrl_q.rx9;
				rd_byte[RX_SREN_BIT]  = rx_ctrl_q.sren;
				rd_byte[RX_CREN_BIT]  = rx_ctrl_q.cren;
				rd_byte[RX_ADDEN_BIT] = rx_ctrl_q.adden;
				rd_byte[RX_FERR_BIT]  = rx_status.framing_error;
				rd_byte[RX_OERR_BIT]  = rx_status.overrun_error;
				rd_byte[RX_RX9D_BIT]  = rx_status.rx_ninth_bit;
			end else if (idx == IDX_BAUD_DIV) begin
				rd_byte = baud_divisor_value_q;
			end
		end
	end

	// Read data captured one edge early so it stands as the access ends
	always_ff @(posedge mclk) begin
		if (rst) begin
			readdata_q <= 32'h0000_0000;
		end else if (read & ~ack_q) begin
			readdata_q <= {24'h00_0000, rd_byte};
		end
	end
	assign readdata = readdata_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_ctrl_q.clock_source_select <= TX_CTRL_RESET[TX_CLOCK_SOURCE_SELECT_BIT];
			tx_ctrl_q.tx9                 <= TX_CTRL_RESET[TX_TX9_BIT];
			tx_ctrl_q.txen                <= TX_CTRL_RESET[TX_TXEN_BIT];
			tx_ctrl_q.sync_mode           <= TX_CTRL_RESET[TX_SYNC_BIT];
			tx_ctrl_q.high_speed_select   <= TX_CTRL_RESET[TX_HIGH_SPEED_SELECT_BIT];
			tx_ctrl_q.tx9d                <= TX_CTRL_RESET[TX_TX9D_BIT];
		end else if (wr_en && idx == IDX_TX_CTRL) begin
			tx_ctrl_q.clock_source_select <= writedata[TX_CLOCK_SOURCE_SELECT_BIT];
			tx_ctrl_q.tx9                 <= writedata[TX_TX9_BIT];
			tx_ctrl_q.txen                <= writedata[TX_TXEN_BIT];
			tx_ctrl_q.sync_mode           <= writedata[TX_SYNC_BIT];
			tx_ctrl_q.high_speed_select   <= writedata[TX_HIGH_SPEED_SELECT_BIT];
			tx_ctrl_q.tx9d                <= writedata[TX_TX9D_BIT];
		end
	end
	assign tx_ctrl = tx_ctrl_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_ctrl_q.port_enable <= RX_CTRL_RESET[RX_PORT_ENABLE_BIT];
			rx_ctrl_q.rx9         <= RX_CTRL_RESET[RX_RX9_BIT];
			rx_ctrl_q.sren        <= RX_CTRL_RESET[RX_SREN_BIT];
			rx_ctrl_q.cren        <= RX_CTRL_RESET[RX_CREN_BIT];
			rx_ctrl_q.adden       <= RX_CTRL_RESET[RX_ADDEN_BIT];
		end else if (wr_en && idx == IDX_RX_CTRL) begin
			rx_ctrl_q.port_enable <= writedata[RX_PORT_ENABLE_BIT];
			rx_ctrl_q.rx9         <= writedata[RX_RX9_BIT];
			rx_ctrl_q.sren        <= writedata[RX_SREN_BIT];
			rx_ctrl_q.cren        <= writedata[RX_CREN_BIT];
			rx_ctrl_q.adden       <= writedata[RX_ADDEN_BIT];
		end
	end
	assign rx_ctrl = rx_ctrl_q;

	// Full 8-bit divisor, zero after reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			baud_divisor_value_q <= BAUD_DIV_RESET;
		end else if (div_write) begin
			baud_divisor_value_q <= writedata[7:0];
		end
	end
	assign div_write = wr_en && (idx == IDX_BAUD_DIV);

	// Generator idles as synchronous slave, clock comes from outside
	assign gen_run = ~(tx_ctrl_q.sync_mode &
		~tx_ctrl_q.clock_source_select);

	// Sync divides by four ahead of the timer
	assign presc_tick = tx_ctrl_q.sync_mode ?
		(presc_q == PRESC_SYNC_LAST) : 1'b1;

	always_ff @(posedge mclk) begin
		if (rst) begin
			presc_q <= 2'h0;
		end else if (div_write || !gen_run || !tx_ctrl_q.sync_mode) begin
			presc_q <= 2'h0;
		end else begin
			presc_q <= presc_q + 2'h1;
		end
	end

	assign timer_pulse = gen_run & presc_tick &
		(bit_rate_timer_q == 8'h00);

	// Down counter, reload at zero, cleared by divisor write
	always_ff @(posedge mclk) begin
		if (rst) begin
			bit_rate_timer_q <= 8'h00;
		end else if (div_write || !gen_run) begin
			bit_rate_timer_q <= 8'h00;
		end else if (presc_tick) begin
			if (bit_rate_timer_q == 8'h00) begin
				bit_rate_timer_q <= baud_divisor_value_q;
			end else begin
				bit_rate_timer_q <= bit_rate_timer_q - 8'h01;
			end
		end
	end

	// Async bit divider of 64 or 16 timer pulses
	assign post_last = tx_ctrl_q.high_speed_select ?
		POST_HIGH_LAST : POST_LOW_LAST;

	// Compare with >= so a speed change mid-count cannot overrun
	always_ff @(posedge mclk) begin
		if (rst) begin
			post_q <= 6'h00;
		end else if (div_write || !gen_run || tx_ctrl_q.sync_mode) begin
			post_q <= 6'h00;
		end else if (timer_pulse) begin
			if (post_q >= post_last) begin
				post_q <= 6'h00;
			end else begin
				post_q <= post_q + 6'h01;
			end
		end
	end

	// Sample clock and bit clock outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			sample_tick_q <= 1'b0;
			bit_tick_q    <= 1'b0;
		end else begin
			sample_tick_q <= timer_pulse & ~div_write;
			if (tx_ctrl_q.sync_mode) begin
				bit_tick_q <= timer_pulse & ~div_write;
			end else begin
				bit_tick_q <= timer_pulse & ~div_write &
					(post_q >= post_last);
			end
		end
	end
	assign sample_tick = sample_tick_q;
	assign bit_tick    = bit_tick_q;

	// Pin crosses three flops; level accepted when stages two and three agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_sync_q  <= 3'h7;
			pin_level_q <= 1'b1;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], receive_data_pin};
			if (pin_sync_q[1] == pin_sync_q[2]) begin
				pin_level_q <= pin_sync_q[2];
			end
		end
	end

	// Majority of three samples taken on the sample clock in async mode
	always_ff @(posedge mclk) begin
		if (rst) begin
			votes_q    <= 3'h7;
			rx_level_q <= 1'b1;
		end else if (tx_ctrl_q.sync_mode) begin
			votes_q    <= {3{pin_level_q}};
			rx_level_q <= pin_level_q;
		end else if (sample_tick_q) begin
			votes_q    <= {votes_q[1:0], pin_level_q};
			rx_level_q <= (votes_q[0] & votes_q[1]) |
				(votes_q[0] & pin_level_q) |
				(votes_q[1] & pin_level_q);
		end
	end
	assign rx_level = rx_level_q;

endmodule

//--- tb_top.sv
// Self-checking bench for the baud generator
`timescale 1ns/1ns
module tb_top
	import sbrg_pkg::*;
;
	logic              mclk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = '0;
	logic [3:0]        byteenable = 4'h1;
	logic              tsr_empty = 1'b1;
	sbrg_rx_stat_t     rx_status = 3'h5;
	logic              receive_data_pin = 1'b1;
	logic [31:0]       readdata;
	logic              waitrequest, sample_tick, bit_tick, rx_level;
	sbrg_tx_ctrl_t     tx_ctrl;
	sbrg_rx_ctrl_t     rx_ctrl;
	int                n_mismatch = 0;
	int                total_checks = 0;
	logic [7:0]        rd;

	sbrg_top dut (.mclk, .rst, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .tsr_empty, .rx_status,
		.receive_data_pin, .tx_ctrl, .rx_ctrl, .sample_tick, .bit_tick,
		.rx_level);

	always #25 mclk = ~mclk;

	task chk(input logic [31:0] s, input logic [31:0] e, input string m);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	// Holds the request until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t bus hang", $time);
		end
	endtask

	task t_regs;
		bus(0, 10'h264, 8'h00);
		chk(rd, 8'h00, "divisor reset");
		bus(0, 10'h260, 8'h00);
		chk(rd, 8'h02, "tx reset");
		bus(0, 10'h060, 8'h00);
		chk(rd, 8'h05, "rx reset");
		bus(1, 10'h060, 8'h90);
		bus(0, 10'h060, 8'h00);
		chk(rd, 8'h95, "rx readback");
		chk(rx_ctrl, 5'h12, "rx ctrl out");
		byteenable <= 4'h0;
		bus(1, 10'h264, 8'h55);
		byteenable <= 4'h1;
		bus(1, 10'h100, 8'hFF);
		bus(0, 10'h100, 8'h00);
		chk(rd, 8'h00, "unmapped read");
		bus(0, 10'h264, 8'h00);
		chk(rd, 8'h00, "divisor untouched");
	endtask

	// Measures one full bit period and the sample ticks inside it
	task t_rate(input logic [7:0] t, x, input int bp, sp);
		int n, s;
		bus(1, 10'h260, t);
		bus(1, 10'h264, x);
		n = 0;
		#1;
		while (bit_tick !== 1'b1 && n < 9000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		n = 0;
		s = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
			if (sample_tick === 1'b1) s++;
		end while (bit_tick !== 1'b1 && n < 9000);
		chk(tx_ctrl, {t[7:4], t[2], t[0]}, "tx ctrl out");
		chk(n, bp, "bit period");
		chk(s, bp / sp, "samples per bit");
	endtask

	task t_restart;
		int n;
		bus(1, 10'h264, 8'h00);
		n = 0;
		#1;
		while (bit_tick !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(n, 16, "restart delay");
	endtask

	task t_slave;
		int n;
		bus(1, 10'h260, 8'h10);
		repeat (4) @(posedge mclk);
		n = 0;
		repeat (200) begin
			@(posedge mclk);
			#1;
			if (sample_tick === 1'b1 || bit_tick === 1'b1) n++;
		end
		chk(n, 0, "ticks with external clock");
	endtask

	// Glitch shorter than a sample gap is seen once and outvoted
	task t_vote;
		int n;
		bus(1, 10'h260, 8'h04);
		bus(1, 10'h264, 8'h07);
		receive_data_pin <= 1'b0;
		repeat (40) @(posedge mclk);
		#1;
		chk(rx_level, 1'b0, "low level");
		@(posedge mclk);
		receive_data_pin <= 1'b1;
		repeat (40) @(posedge mclk);
		#1;
		chk(rx_level, 1'b1, "high level");
		@(posedge mclk);
		receive_data_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		receive_data_pin <= 1'b1;
		n = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (rx_level !== 1'b1) n++;
		end
		chk(n, 0, "glitch passed");
	endtask

	// Reset in mid-run must clear divisor and mode
	task t_reset;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		bus(0, 10'h264, 8'h00);
		chk(rd, 8'h00, "divisor after reset");
		bus(0, 10'h260, 8'h00);
		chk(rd, 8'h02, "tx after reset");
	endtask

	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_rate(8'h00, 8'h02, 192, 3);
		t_rate(8'h04, 8'h03, 64, 4);
		t_rate(8'h04, 8'hFF, 4096, 256);
		t_restart();
		t_rate(8'h90, 8'h01, 8, 8);
		t_rate(8'h94, 8'h01, 8, 8);
		t_slave();
		t_vote();
		t_reset();
		summarize();
	end

	initial begin
		#2000000;
		n_mismatch++;
		summarize();
	end
endmodule

bind sbrg_top sbrg_monitor u_mon (.mclk, .rst, .address, .read, .write,
	.writedata, .byteenable, .readdata, .waitrequest, .tx_ctrl,
	.sample_tick, .bit_tick, .rx_level);
